// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import radio_cfg_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic tx_data_i = 1'b0;
  logic rx_data_i = 1'b0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [22:0] second_frequency_word_o;
  logic second_dither_enable_o;
  logic [3:0] first_osc_core_current_o;
  logic [3:0] second_osc_core_current_o;
  logic reference_clk_en_o, modem_clk_en_o, symbol_tick_o, adc_clk_en_o;
  logic tx_line_o, rx_bit_o, data_clock_output_o;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  radio_cfg_b_modem dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .tx_data_i(tx_data_i),
    .rx_data_i(rx_data_i),
    .second_frequency_word_o(second_frequency_word_o),
    .second_dither_enable_o(second_dither_enable_o),
    .first_osc_core_current_o(first_osc_core_current_o),
    .second_osc_core_current_o(second_osc_core_current_o),
    .reference_clk_en_o(reference_clk_en_o),
    .modem_clk_en_o(modem_clk_en_o), .symbol_tick_o(symbol_tick_o),
    .adc_clk_en_o(adc_clk_en_o), .tx_line_o(tx_line_o),
    .rx_bit_o(rx_bit_o), .data_clock_output_o(data_clock_output_o));

  always #10 clk_i = ~clk_i;

  //////////////////////////////////////////////////////////////////////
  // common tasks
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      failures++;
      close_out();
    end
  end

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1)
    begin
      failures++;
      $display("[FAIL] bus ack expected 1 seen %b", ack_o);
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_check(string name, input logic [7:0] a,
                          input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    check(name, {24'h0, e}, q);
  endtask

  function automatic logic sig(int which);
    case (which)
      0: return reference_clk_en_o;
      1: return symbol_tick_o;
      3: return modem_clk_en_o;
      default: return adc_clk_en_o;
    endcase
  endfunction

  // ends at the edge where the pulse is seen, so gaps count edges
  task automatic wait_pulse(int which, output int n);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (sig(which) !== 1'b1 && n < 20000);
    if (sig(which) !== 1'b1)
    begin
      failures++;
      $display("[FAIL] pulse %0d expected 1 seen %b", which, sig(which));
    end
  endtask

  task automatic measure(int which, output int gap);
    int n;
    wait_pulse(which, n);
    wait_pulse(which, n);
    wait_pulse(which, gap);
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [7:0] rv [6] = '{8'h83, 8'hBD, 8'hF9, 8'h50, 8'h88, 8'h30};
    for (int i = 0; i < 6; i++)
      rd_check("reset value", 8'h20 + 8'(4 * i), rv[i]);
    check("freq word", 32'h41DEFC, 32'(second_frequency_word_o));
    check("dither", 32'h1, 32'(second_dither_enable_o));
    $display("test reset values done");
  endtask

  task automatic t_write();
    wr(8'h20, 8'h12);
    wr(8'h24, 8'h34);
    wr(8'h28, 8'h56);
    check("freq word", 32'h091A2B, 32'(second_frequency_word_o));
    check("dither off", 32'h0, 32'(second_dither_enable_o));
    wr(8'h30, 8'h84);
    check("current a", 32'h8, 32'(first_osc_core_current_o));
    check("current b", 32'h4, 32'(second_osc_core_current_o));
    wr(8'h34, 8'hFF);
    rd_check("modem reserved", 8'h34, 8'h77);
    wr(8'h00, 8'hAA);
    rd_check("unmapped", 8'h00, 8'h00);
    $display("test register writes done");
  endtask

  task automatic t_dividers();
    int gap;
    do_reset();
    for (int c = 1; c < 8; c++)
    begin
      wr(8'h2C, 8'((c << 5) | 8'h10));
      measure(0, gap);
      check("reference gap", c + 1, gap);
      wr(8'h34, 8'(c << 4));
      measure(2, gap);
      check("adc gap", 2 * c + 2, gap);
    end
    // code 7 brings a 50 MHz crystal nearest the wanted adc rate
    wr(8'h34, 8'h70);
    measure(2, gap);
    check("adc nearest code", 16, gap);
    $display("test reference and adc dividers done");
  endtask

  task automatic t_symbol();
    int hs [8] = '{5, 6, 8, 15, 25, 80, 96, 128};
    int gap;
    do_reset();
    // rising targets keep the divider accumulator below the new target
    for (int d1 = 0; d1 < 8; d1++)
    begin
      wr(8'h2C, 8'(8'h20 | (d1 << 2)));
      measure(1, gap);
      check("symbol gap div1", 8 * hs[d1], gap);
      if (d1 == 2)
      begin
        measure(3, gap);
        check("modem gap", 8, gap);
      end
    end
    for (int d2 = 1; d2 < 4; d2++)
    begin
      wr(8'h2C, 8'(8'h3C | d2));
      measure(1, gap);
      check("symbol gap div2", 8 * (128 << d2), gap);
    end
    $display("test modem and symbol rate done");
  endtask

  task automatic count_ones(output int ones);
    int n;
    wait_pulse(1, n);
    wait_pulse(1, n);
    ones = 0;
    repeat (40)
    begin
      @(posedge clk_i);
      ones += int'(tx_line_o === 1'b1);
    end
  endtask

  task automatic t_format();
    int ones;
    int cl;
    wr(8'h2C, 8'h20);
    tx_data_i <= 1'b1;
    wr(8'h34, {6'h0C, fmt_nrz});
    count_ones(ones);
    check("nrz high count", 40, ones);
    wr(8'h34, {6'h0C, fmt_manchester});
    count_ones(ones);
    check("manchester high count", 20, ones);
    for (int f = 2; f < 4; f++)
    begin
      wr(8'h34, 8'(8'h30 | f));
      cl = 0;
      repeat (100)
      begin
        @(posedge clk_i);
        cl += int'(data_clock_output_o === 1'(f - 2));
      end
      check("uart data clock", 100, cl);
    end
    $display("test data formats done");
  endtask

  task automatic t_scramble();
    int n;
    int ones;
    tx_data_i <= 1'b0;
    rx_data_i <= 1'b0;
    wr(8'h34, 8'h34);
    ones = 0;
    for (int i = 0; i < 16; i++)
    begin
      wait_pulse(1, n);
      repeat (4) @(posedge clk_i);
      if (i < 4)
        check("pn first bits", 1, 32'(tx_line_o));
      check("pn tx equals rx", 32'(tx_line_o), 32'(rx_bit_o));
      ones += int'(tx_line_o === 1'b1);
    end
    check("pn mixed bits", 1, 32'(ones > 4 && ones < 16));
    wr(8'h34, 8'h30);
    count_ones(ones);
    check("scramble off", 0, ones);
    $display("test scrambler done");
  endtask

  initial
  begin
    do_reset();
    t_reset();
    t_write();
    t_dividers();
    t_symbol();
    t_format();
    t_scramble();
    close_out();
  end
endmodule

// [verilog/radio_cfg_b_modem.sv]
`timescale 1ns/1ps
`include "radio_cfg_regs.svh"
module radio_cfg_b_modem
  import radio_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic tx_data_i,
  input wire logic rx_data_i,
  output logic [22:0] second_frequency_word_o,
  output logic second_dither_enable_o,
  output logic [3:0] first_osc_core_current_o,
  output logic [3:0] second_osc_core_current_o,
  output logic reference_clk_en_o,
  output logic modem_clk_en_o,
  output logic symbol_tick_o,
  output logic adc_clk_en_o,
  output logic tx_line_o,
  output logic rx_bit_o,
  output logic data_clock_output_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // code 0 is not supported, treated as code 1
  function automatic logic [2:0] fix_code(input logic [2:0] c);
    fix_code = (c == 3'h0) ? 3'h1 : c;
  endfunction

  function automatic logic [7:0] div1_halves(input logic [2:0] c);
    case (c)
      3'h0: div1_halves = `DIV1_H0;
      3'h1: div1_halves = `DIV1_H1;
      3'h2: div1_halves = `DIV1_H2;
      3'h3: div1_halves = `DIV1_H3;
      3'h4: div1_halves = `DIV1_H4;
      3'h5: div1_halves = `DIV1_H5;
      3'h6: div1_halves = `DIV1_H6;
      default: div1_halves = `DIV1_H7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [7:0] freq_high_r;
  logic [7:0] freq_mid_r;
  logic [7:0] freq_low_r;
  logic [7:0] clock_b_r;
  logic [7:0] osc_cur_r;
  logic [7:0] modem_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [2:0] ref_cnt_r;
  logic ref_tick_r;
  logic [3:0] adc_cnt_r;
  logic adc_tick_r;
  logic [10:0] acc_r;
  logic modem_tick_r;
  logic [2:0] sym_cnt_r;
  logic sym_tick_r;
  logic [8:0] lfsr_r [2];
  logic bit_r [2];
  logic tx_line_r;
  logic data_clock_r;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [5:0] idx;
  logic bus_req;
  logic rd_take;
  logic wr_en;
  logic hit_high;
  logic hit_mid;
  logic hit_low;
  logic hit_clock;
  logic hit_cur;
  logic hit_modem;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  assign idx = adr_i[7:2];
  assign bus_req = cyc_i & stb_i;
  assign rd_take = bus_req & ~ack_r & ~we_i;
  // write lands on the edge where the master sees ack
  assign wr_en = bus_req & we_i & ack_r & sel_i[0];
  assign hit_high = (idx == `IDX_FREQ_HIGH);
  assign hit_mid = (idx == `IDX_FREQ_MID);
  assign hit_low = (idx == `IDX_FREQ_LOW);
  assign hit_clock = (idx == `IDX_CLOCK_B);
  assign hit_cur = (idx == `IDX_OSC_CUR);
  assign hit_modem = (idx == `IDX_MODEM);
  assign status_byte = {sym_cnt_r, data_clock_r, tx_line_r, bit_r[1],
                        bit_r[0], acc_r == 11'h000};

  always_comb
  begin
    if (hit_high)
      rd_byte = freq_high_r;
    else if (hit_mid)
      rd_byte = freq_mid_r;
    else if (hit_low)
      rd_byte = freq_low_r;
    else if (hit_clock)
      rd_byte = clock_b_r;
    else if (hit_cur)
      rd_byte = osc_cur_r;
    else if (hit_modem)
      rd_byte = modem_r;
    else if (idx == `IDX_STATUS)
      rd_byte = status_byte;
    else
      rd_byte = 8'h00;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req & ~ack_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= 32'h0000_0000;
    else if (rd_take)
      dat_r <= {24'h00_0000, rd_byte};
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      freq_high_r <= `RST_FREQ_HIGH;
      freq_mid_r <= `RST_FREQ_MID;
      freq_low_r <= `RST_FREQ_LOW;
      clock_b_r <= `RST_CLOCK_B;
      osc_cur_r <= `RST_OSC_CUR;
      modem_r <= `RST_MODEM;
    end
    else if (wr_en)
    begin
      if (hit_high)
        freq_high_r <= dat_i[7:0];
      if (hit_mid)
        freq_mid_r <= dat_i[7:0];
      if (hit_low)
        freq_low_r <= dat_i[7:0];
      if (hit_clock)
        clock_b_r <= dat_i[7:0];
      if (hit_cur)
        osc_cur_r <= dat_i[7:0];
      // reserved modem bits are kept at zero
      if (hit_modem)
        modem_r <= dat_i[7:0] & `MODEM_WR_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field views

  logic [2:0] ref_eff;
  logic [2:0] adc_eff;
  logic [2:0] div1_code;
  logic [1:0] div2_code;
  logic scr_en;
  data_format_t fmt;

  assign ref_eff = fix_code(clock_b_r[`REF_DIV_HI:`REF_DIV_LO]);
  assign adc_eff = fix_code(modem_r[`ADC_DIV_HI:`ADC_DIV_LO]);
  assign div1_code = clock_b_r[`DIV1_HI:`DIV1_LO];
  assign div2_code = clock_b_r[`DIV2_HI:`DIV2_LO];
  assign scr_en = modem_r[`SCRAMBLE_BIT];
  assign fmt = data_format_t'(modem_r[`FMT_HI:`FMT_LO]);

  ////////////////////////////////////////////////////////////////////////
  // reference clock enable, divide by code plus one

  logic ref_hit;

  assign ref_hit = (ref_cnt_r >= ref_eff);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_cnt_r <= 3'h0;
      ref_tick_r <= 1'b0;
    end
    else
    begin
      ref_cnt_r <= ref_hit ? 3'h0 : ref_cnt_r + 3'h1;
      ref_tick_r <= ref_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // adc clock enable, divide by twice code plus two

  logic [3:0] adc_limit;
  logic adc_hit;

  assign adc_limit = {adc_eff, 1'b1};
  assign adc_hit = (adc_cnt_r >= adc_limit);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      adc_cnt_r <= 4'h0;
      adc_tick_r <= 1'b0;
    end
    else
    begin
      adc_cnt_r <= adc_hit ? 4'h0 : adc_cnt_r + 4'h1;
      adc_tick_r <= adc_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // modem clock enable, fractional in half reference periods

  logic [10:0] mod_target;
  logic [10:0] acc_sum;
  logic mod_hit;
  logic [10:0] acc_nxt;

  // product of divider one and divider two
  assign mod_target = {3'h0, div1_halves(div1_code)} << div2_code;
  assign acc_sum = acc_r + `HALF_STEP;
  assign mod_hit = ref_hit & (acc_sum >= mod_target);
  assign acc_nxt = mod_hit ? acc_sum - mod_target :
                   ref_hit ? acc_sum : acc_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_r <= 11'h000;
      modem_tick_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      modem_tick_r <= mod_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // symbol timing, eight modem periods each

  logic sym_hit;

  assign sym_hit = mod_hit & (sym_cnt_r == `SYMBOL_LAST);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sym_cnt_r <= 3'h0;
      sym_tick_r <= 1'b0;
    end
    else
    begin
      if (mod_hit)
        sym_cnt_r <= sym_cnt_r + 3'h1;
      sym_tick_r <= sym_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scramblers, lane 0 transmit, lane 1 receive

  logic din [2];

  assign din[0] = tx_data_i;
  assign din[1] = rx_data_i;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_lane
      logic fb;
      assign fb = lfsr_r[g][8] ^ lfsr_r[g][4];
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          lfsr_r[g] <= `PN_SEED;
        else if (!scr_en)
          lfsr_r[g] <= `PN_SEED;
        else if (sym_hit)
          lfsr_r[g] <= {lfsr_r[g][7:0], fb};
      end
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          bit_r[g] <= 1'b0;
        else if (sym_hit)
          bit_r[g] <= din[g] ^ (scr_en & lfsr_r[g][8]);
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // line coding and data clock

  logic line_nxt;
  logic data_clock_output_nxt;

  always_comb
  begin
    case (fmt)
      fmt_nrz:
      begin
        line_nxt = bit_r[0];
        data_clock_output_nxt = ~sym_cnt_r[2];
      end
      fmt_manchester:
      begin
        line_nxt = bit_r[0] ^ sym_cnt_r[2];
        data_clock_output_nxt = ~sym_cnt_r[2];
      end
      fmt_uart_low:
      begin
        line_nxt = tx_data_i;
        data_clock_output_nxt = 1'b0;
      end
      default:
      begin
        line_nxt = tx_data_i;
        data_clock_output_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_line_r <= 1'b0;
      data_clock_r <= 1'b0;
    end
    else
    begin
      tx_line_r <= line_nxt;
      data_clock_r <= data_clock_output_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign second_frequency_word_o = {freq_high_r, freq_mid_r,
                                    freq_low_r[`FREQ_LOW_HI:`FREQ_LOW_LO]};
  assign second_dither_enable_o = freq_low_r[`DITHER_BIT];
  assign first_osc_core_current_o = osc_cur_r[`CUR_A_HI:`CUR_A_LO];
  assign second_osc_core_current_o = osc_cur_r[`CUR_B_HI:`CUR_B_LO];
  assign reference_clk_en_o = ref_tick_r;
  assign modem_clk_en_o = modem_tick_r;
  assign symbol_tick_o = sym_tick_r;
  assign adc_clk_en_o = adc_tick_r;
  assign tx_line_o = tx_line_r;
  assign rx_bit_o = bit_r[1];
  assign data_clock_output_o = data_clock_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking

  sequence s_new_req;
    cyc_i && stb_i && !ack_r;
  endsequence

  sequence s_one_ack;
    ack_r ##1 !ack_r;
  endsequence

  a_ack_follows_req: assert property (
    disable iff (rst_i) s_new_req |=> s_one_ack)
    else $error("ack missing or longer than one cycle");

  a_freq_reset_high: assert property (
    rst_i |=> (second_frequency_word_o[22:15] == 8'h83) &&
      second_dither_enable_o)
    else $error("frequency word or dither wrong after reset");

  a_freq_write_mid: assert property (
    disable iff (rst_i)
    wr_en && hit_mid |=> second_frequency_word_o[14:7] == $past(dat_i[7:0]))
    else $error("middle frequency byte not written");

  a_ref_spacing: assert property (
    disable iff (rst_i) ref_tick_r |=> !ref_tick_r)
    else $error("reference enable on two adjacent cycles");

  a_adc_min_gap: assert property (
    disable iff (rst_i) adc_tick_r |=> !adc_tick_r [*3])
    else $error("adc enable faster than divide by four");

  a_modem_on_ref: assert property (
    disable iff (rst_i) modem_tick_r |-> ref_tick_r)
    else $error("modem enable without reference enable");

  a_symbol_eight: assert property (
    disable iff (rst_i) sym_tick_r |-> modem_tick_r && sym_cnt_r == 3'h0)
    else $error("symbol tick not on eighth modem period");

  a_scramble_off: assert property (
    disable iff (rst_i)
    sym_hit && !scr_en |=> bit_r[0] == $past(tx_data_i))
    else $error("data altered while scrambling is off");

  a_uart_data_clock_output: assert property (
    disable iff (rst_i)
    fmt[1] |=> data_clock_r == $past(fmt[0]) && tx_line_r == $past(tx_data_i))
    else $error("uart mode clock level or line wrong");

endmodule

// [verilog/radio_cfg_pkg.sv]
package radio_cfg_pkg;

  typedef enum logic [1:0] {
    fmt_nrz,
    fmt_manchester,
    fmt_uart_low,
    fmt_uart_high
  } data_format_t;

endpackage

// [verilog/radio_cfg_regs.svh]
`ifndef RADIO_CFG_REGS_SVH
`define RADIO_CFG_REGS_SVH

////////////////////////////////////////////////////////////////////////
// register indices, byte address is four times the index
`define IDX_FREQ_HIGH 6'h08
`define IDX_FREQ_MID 6'h09
`define IDX_FREQ_LOW 6'h0A
`define IDX_CLOCK_B 6'h0B
`define IDX_OSC_CUR 6'h0C
`define IDX_MODEM 6'h0D
`define IDX_STATUS 6'h3F

////////////////////////////////////////////////////////////////////////
// reset values
`define RST_FREQ_HIGH 8'h83
`define RST_FREQ_MID 8'hBD
`define RST_FREQ_LOW 8'hF9
`define RST_CLOCK_B 8'h50
`define RST_OSC_CUR 8'h88
`define RST_MODEM 8'h30

////////////////////////////////////////////////////////////////////////
// field positions
`define FREQ_LOW_HI 7
`define FREQ_LOW_LO 1
`define DITHER_BIT 0
`define REF_DIV_HI 7
`define REF_DIV_LO 5
`define DIV1_HI 4
`define DIV1_LO 2
`define DIV2_HI 1
`define DIV2_LO 0
`define CUR_A_HI 7
`define CUR_A_LO 4
`define CUR_B_HI 3
`define CUR_B_LO 0
`define ADC_DIV_HI 6
`define ADC_DIV_LO 4
`define SCRAMBLE_BIT 2
`define FMT_HI 1
`define FMT_LO 0
`define MODEM_WR_MASK 8'h77

////////////////////////////////////////////////////////////////////////
// divider constants, first modem divider in half steps
`define DIV1_H0 8'h05
`define DIV1_H1 8'h06
`define DIV1_H2 8'h08
`define DIV1_H3 8'h0F
`define DIV1_H4 8'h19
`define DIV1_H5 8'h50
`define DIV1_H6 8'h60
`define DIV1_H7 8'h80
`define HALF_STEP 11'h002
`define SYMBOL_LAST 3'h7
`define PN_SEED 9'h1FF

`endif
